// File: src/sbr_map.vh
// Register map, field positions, reset values and clock counts of the secondary reset block
`ifndef SBR_MAP_VH
`define SBR_MAP_VH

// Register byte offsets
`define SBR_OFS_BRIDGE_CTRL 8'h3C
`define SBR_OFS_HP_CTRL 8'h48
`define SBR_OFS_STRAP_STAT 8'h50
`define SBR_OFS_INT_STATUS 8'h54
`define SBR_OFS_INT_MASK 8'h58

// Bridge control fields
`define SBR_BIT_SW_RESET 0

// Hot plug control fields
`define SBR_BIT_HP_FIRST 0
`define SBR_BIT_HP_SECOND 1
`define SBR_BIT_M66_DRIVE 2
`define SBR_BIT_IRQ_DRIVE 3

// Strap and pin status fields
`define SBR_BIT_ST_M66 0
`define SBR_BIT_ST_PCIX 1
`define SBR_BIT_ST_SECRST 2
`define SBR_BIT_ST_HPMODE 3
`define SBR_BIT_ST_SDATA 4
`define SBR_BIT_ST_IRQ_LO 8
`define SBR_IRQ_LINES 4

// Interrupt status and mask fields
`define SBR_BIT_EV_PME 0
`define SBR_BIT_EV_PERR 1
`define SBR_BIT_EV_RELEASE 2
`define SBR_NUM_EVENTS 3

// Reset values
`define SBR_RST_BRIDGE_CTRL 1'h0
`define SBR_RST_HP_CTRL 4'h0
`define SBR_RST_INT_MASK 3'h0

// Bus clock half periods in core cycles
`define SBR_HALF_33 4'h1
`define SBR_HALF_66 4'h1
`define SBR_HALF_PCIX 4'h1
`define SBR_NUM_BUS_CLK 5

`endif

// File: src/sbr_strap_capture.v
// Strap latch that captures a strap level on the release edge of the secondary reset
`timescale 1ns/10ps
module sbr_strap_capture #(
    parameter WIDTH = 1
) (
    // Clock and chip reset
    input wire pclk,
    input wire presetn,
    // Capture control
    input wire release_now,
    input wire capture_en,
    // Strap level and held value
    input wire [WIDTH-1:0] strap_in,
    output reg [WIDTH-1:0] strap_held
);

    // Straps that move after the release edge are ignored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_held <= {WIDTH{1'b0}};
        end else if (release_now && capture_en) begin
            strap_held <= strap_in;
        end
    end

endmodule // sbr_strap_capture

// File: src/sbr_secondary_reset.v
// Secondary bus reset, strap capture, alternate pin functions and APB registers
`timescale 1ns/10ps
`include "sbr_map.vh"

// Behaviour
// R1 - Secondary reset output is low whenever chip reset is low.
// R2 - Secondary reset output also stays low while software reset bit is set.
// R3 - Secondary reset never resets internal logic; only bus agents see it.
// R4 - No hardware wait after reset release; software times first configuration access.
// R5 - Outside hot plug, speed strap is captured at secondary reset rising edge.
// R6 - After release, changes on the speed strap are ignored.
// R7 - In hot plug mode after release, speed pin may be driven low open-drain.
// R8 - Capability strap captured at release edge picks bus mode, then ignored.
// R9 - Five secondary bus clock outputs are provided.
// R10 - Hot plug mode turns fifth clock pin into serial data input.
// R11 - Parity error pin reports secondary bus parity errors only.
// R12 - First interrupt line is input or open-drain output; other three inputs.
// R13 - Open-drain power event output asserted on hot plug power events.
// R14 - 64-bit request pin held asserted while secondary reset is asserted.
// R15 - Captured speed strap high selects 66 MHz, low selects 33 MHz.
module sbr_secondary_reset (
    // Clock and chip reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Secondary bus reset
    output reg sec_reset_n,
    // Speed strap pin
    input wire m66en_in,
    output reg m66en_out,
    output reg m66en_oe,
    // Capability strap
    input wire pcixcap_in,
    // Bus clocks, lowest four
    output reg [3:0] bus_clk,
    // Fifth clock pin, shared with serial input data
    input wire bus_clk4_in,
    output reg bus_clk4_out,
    output reg bus_clk4_oe,
    output reg hp_serial_in_data,
    // Selected speed and mode
    output reg bus_66mhz,
    output reg bus_pcix,
    // Parity error pin
    input wire sec_parity_err,
    output reg perr_n_out,
    output reg perr_n_oe,
    // Interrupt lines
    input wire irq_line_first_in,
    output reg irq_line_first_out,
    output reg irq_line_first_oe,
    input wire [2:0] irq_lines_in,
    // Power event pin
    input wire hp_power_event,
    output reg pme_n_out,
    output reg pme_n_oe,
    // 64-bit request pin
    output reg req64_n_out,
    output reg req64_n_oe,
    // Interrupt output
    output reg irq
);

    // Software controls
    reg sw_secondary_reset_bit;
    reg hotplug_enable_first;
    reg hotplug_enable_second;
    reg m66_drive_low;
    reg irq_first_drive_low;
    reg [`SBR_NUM_EVENTS-1:0] int_status;
    reg [`SBR_NUM_EVENTS-1:0] int_mask;

    // Bus transfer state
    reg [`SBR_NUM_EVENTS-1:0] read_clear;

    // Clock generator
    reg [3:0] div_cnt;
    reg clk_phase;

    wire held_m66;
    wire held_pcix;

    wire hotplug_mode = hotplug_enable_first | hotplug_enable_second;
    wire next_sec_reset_n = ~sw_secondary_reset_bit;
    wire release_now = next_sec_reset_n & ~sec_reset_n;
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire wr_done = access_done & pwrite;
    wire [3:0] half_period = held_pcix ? `SBR_HALF_PCIX :
                             (held_m66 ? `SBR_HALF_66 : `SBR_HALF_33);
    wire [`SBR_NUM_EVENTS-1:0] events;

    // Address decode used in the setup phase only
    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = (addr == `SBR_OFS_BRIDGE_CTRL) ||
                        (addr == `SBR_OFS_HP_CTRL) ||
                        (addr == `SBR_OFS_STRAP_STAT) ||
                        (addr == `SBR_OFS_INT_STATUS) ||
                        (addr == `SBR_OFS_INT_MASK);
        end
    endfunction

    // Secondary reset: chip reset forces it low, software holds it low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_reset_n <= 1'b0; // R1
        end else begin
            sec_reset_n <= next_sec_reset_n; // R2
        end
    end
    // Nothing inside is reset by sec_reset_n; it only drives the pin. R3
    // No settle timer after release; software must wait before config cycles. R4

    // Speed strap only counts outside hot plug mode
    sbr_strap_capture #(
        .WIDTH(1)
    ) u_m66_capture (
        .pclk(pclk),
        .presetn(presetn),
        .release_now(release_now), // R6
        .capture_en(~hotplug_mode), // R5
        .strap_in(m66en_in),
        .strap_held(held_m66)
    );

    sbr_strap_capture #(
        .WIDTH(1)
    ) u_pcix_capture (
        .pclk(pclk),
        .presetn(presetn),
        .release_now(release_now), // R8
        .capture_en(1'b1),
        .strap_in(pcixcap_in),
        .strap_held(held_pcix)
    );

    // Selected speed and mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_66mhz <= 1'b0;
            bus_pcix <= 1'b0;
        end else begin
            bus_66mhz <= held_m66; // R15
            bus_pcix <= held_pcix; // R8
        end
    end

    // Speed pin drive in hot plug mode, only once the bus is out of reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m66en_out <= 1'b0;
            m66en_oe <= 1'b0;
        end else begin
            m66en_out <= 1'b0;
            m66en_oe <= hotplug_mode & sec_reset_n & m66_drive_low; // R7
        end
    end

    // Bus clock divider; core clock limits the real rate, half periods are the knob
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
            clk_phase <= 1'b0;
        end else if (div_cnt + 4'h1 >= half_period) begin
            div_cnt <= 4'h0;
            clk_phase <= ~clk_phase;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_clk <= 4'h0;
            bus_clk4_out <= 1'b0;
            bus_clk4_oe <= 1'b0;
            hp_serial_in_data <= 1'b0;
        end else begin
            bus_clk <= {4{clk_phase}}; // R9
            bus_clk4_out <= clk_phase & ~hotplug_mode; // R9
            bus_clk4_oe <= ~hotplug_mode; // R10
            hp_serial_in_data <= hotplug_mode ? bus_clk4_in : 1'b0; // R10
        end
    end

    // Parity error pin follows secondary bus parity errors only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perr_n_out <= 1'b0;
            perr_n_oe <= 1'b0;
        end else begin
            perr_n_out <= 1'b0;
            perr_n_oe <= sec_parity_err; // R11
        end
    end

    // First interrupt line doubles as an open-drain output for hot plug
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_line_first_out <= 1'b0;
            irq_line_first_oe <= 1'b0;
        end else begin
            irq_line_first_out <= 1'b0;
            irq_line_first_oe <= irq_first_drive_low; // R12
        end
    end

    // 64-bit request held asserted during secondary reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req64_n_out <= 1'b0;
            req64_n_oe <= 1'b1; // R14
        end else begin
            req64_n_out <= 1'b0;
            req64_n_oe <= ~next_sec_reset_n; // R14
        end
    end

    // Sticky events; a new event beats a read clear in the same cycle
    assign events[`SBR_BIT_EV_PME] = hp_power_event;
    assign events[`SBR_BIT_EV_PERR] = sec_parity_err;
    assign events[`SBR_BIT_EV_RELEASE] = release_now;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= {`SBR_NUM_EVENTS{1'b0}};
        end else if (access_done && !pwrite && paddr == `SBR_OFS_INT_STATUS) begin
            int_status <= (int_status & ~read_clear) | events;
        end else begin
            int_status <= int_status | events;
        end
    end

    // Power event pin held low while its event is pending
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pme_n_out <= 1'b0;
            pme_n_oe <= 1'b0;
            irq <= 1'b0;
        end else begin
            pme_n_out <= 1'b0;
            pme_n_oe <= int_status[`SBR_BIT_EV_PME] | hp_power_event; // R13
            irq <= |(int_status & int_mask);
        end
    end

    // Register writes take effect at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_secondary_reset_bit <= `SBR_RST_BRIDGE_CTRL;
            {irq_first_drive_low, m66_drive_low, hotplug_enable_second, hotplug_enable_first} <= `SBR_RST_HP_CTRL;
            int_mask <= `SBR_RST_INT_MASK;
        end else if (wr_done) begin
            case (paddr)
                `SBR_OFS_BRIDGE_CTRL: begin
                    sw_secondary_reset_bit <= pwdata[`SBR_BIT_SW_RESET]; // R2
                end
                `SBR_OFS_HP_CTRL: begin
                    hotplug_enable_first <= pwdata[`SBR_BIT_HP_FIRST];
                    hotplug_enable_second <= pwdata[`SBR_BIT_HP_SECOND];
                    m66_drive_low <= pwdata[`SBR_BIT_M66_DRIVE];
                    irq_first_drive_low <= pwdata[`SBR_BIT_IRQ_DRIVE];
                end
                `SBR_OFS_INT_MASK: begin
                    int_mask <= pwdata[`SBR_NUM_EVENTS-1:0];
                end
                default: begin
                    sw_secondary_reset_bit <= sw_secondary_reset_bit;
                end
            endcase
        end
    end

    // Read data and answer built in setup so every bus output is a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            read_clear <= {`SBR_NUM_EVENTS{1'b0}};
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= ~is_mapped(paddr);
            prdata <= 32'h0;
            read_clear <= {`SBR_NUM_EVENTS{1'b0}};
            if (!pwrite) begin
                case (paddr)
                    `SBR_OFS_BRIDGE_CTRL: begin
                        prdata[`SBR_BIT_SW_RESET] <= sw_secondary_reset_bit;
                    end
                    `SBR_OFS_HP_CTRL: begin
                        prdata[`SBR_BIT_HP_FIRST] <= hotplug_enable_first;
                        prdata[`SBR_BIT_HP_SECOND] <= hotplug_enable_second;
                        prdata[`SBR_BIT_M66_DRIVE] <= m66_drive_low;
                        prdata[`SBR_BIT_IRQ_DRIVE] <= irq_first_drive_low;
                    end
                    `SBR_OFS_STRAP_STAT: begin
                        prdata[`SBR_BIT_ST_M66] <= held_m66;
                        prdata[`SBR_BIT_ST_PCIX] <= held_pcix;
                        prdata[`SBR_BIT_ST_SECRST] <= sec_reset_n;
                        prdata[`SBR_BIT_ST_HPMODE] <= hotplug_mode;
                        prdata[`SBR_BIT_ST_SDATA] <= hp_serial_in_data;
                        prdata[`SBR_BIT_ST_IRQ_LO +: `SBR_IRQ_LINES] <= {irq_lines_in, irq_line_first_in}; // R12
                    end
                    `SBR_OFS_INT_STATUS: begin
                        prdata[`SBR_NUM_EVENTS-1:0] <= int_status;
                        read_clear <= int_status;
                    end
                    `SBR_OFS_INT_MASK: begin
                        prdata[`SBR_NUM_EVENTS-1:0] <= int_mask;
                    end
                    default: begin
                        prdata <= 32'h0;
                    end
                endcase
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // sbr_secondary_reset

// File: tb/sbr_assertions.sv
// Checker of the secondary reset block ports
`timescale 1ns/10ps
module sbr_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Reset and straps
    input wire sec_reset_n,
    input wire req64_n_oe,
    input wire m66en_in,
    input wire pcixcap_in,
    input wire bus_66mhz,
    input wire bus_pcix,
    // Shared pins
    input wire bus_clk4_in,
    input wire bus_clk4_oe,
    input wire hp_serial_in_data,
    input wire sec_parity_err,
    input wire perr_n_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr == 8'h3C || paddr == 8'h48 || paddr == 8'h50 || paddr == 8'h54 || paddr == 8'h58;
    sequence s_setup; psel && !penable; endsequence
    sequence s_ctrl_wr; psel && penable && pready && pwrite && paddr == 8'h3C; endsequence
    // Three high samples so the capture edge has settled
    sequence s_released; sec_reset_n [*3]; endsequence
    property p_req64; req64_n_oe == !sec_reset_n; endproperty
    property p_ready; s_setup |=> pready ##1 !pready; endproperty
    property p_slverr; pready |-> pslverr == !mapped; endproperty
    property p_swrst; s_ctrl_wr |-> ##2 sec_reset_n == !$past(pwdata[0], 2); endproperty
    property p_hold; s_released |-> $stable(bus_66mhz) && $stable(bus_pcix); endproperty
    property p_cap; $rose(sec_reset_n) |=> bus_pcix == $past(pcixcap_in, 2); endproperty
    property p_m66; $rose(sec_reset_n) && bus_clk4_oe |=> bus_66mhz == $past(m66en_in, 2); endproperty
    property p_perr; perr_n_oe == $past(sec_parity_err); endproperty
    property p_serial; !bus_clk4_oe [*2] |-> hp_serial_in_data == $past(bus_clk4_in); endproperty
    a_req64: assert property (p_req64) else $error("req64 drive off");
    a_ready: assert property (p_ready) else $error("ready pulse off");
    a_slverr: assert property (p_slverr) else $error("slave error off");
    a_swrst: assert property (p_swrst) else $error("software reset off");
    a_hold: assert property (p_hold) else $error("strap moved");
    a_cap: assert property (p_cap) else $error("mode strap lost");
    a_m66: assert property (p_m66) else $error("speed strap lost");
    a_perr: assert property (p_perr) else $error("parity pin off");
    a_serial: assert property (p_serial) else $error("serial data off");
endmodule // sbr_checker
bind sbr_secondary_reset sbr_checker i_sbr_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sec_reset_n(sec_reset_n), .req64_n_oe(req64_n_oe), .m66en_in(m66en_in), .pcixcap_in(pcixcap_in),
    .bus_66mhz(bus_66mhz), .bus_pcix(bus_pcix), .bus_clk4_in(bus_clk4_in), .bus_clk4_oe(bus_clk4_oe),
    .hp_serial_in_data(hp_serial_in_data), .sec_parity_err(sec_parity_err), .perr_n_oe(perr_n_oe));

// File: tb/sbr_agent.sv
// Bus agent model: strap resistors, interrupt pins and serial data source
`timescale 1ns/10ps
module sbr_agent (
    // Levels set by the bench
    input wire m66_strap,
    input wire cap_strap,
    input wire sdata,
    input wire [3:0] irq_pins,
    // Device drives
    input wire m66en_oe,
    input wire irq_line_first_oe,
    input wire bus_clk4_oe,
    input wire bus_clk4_out,
    // Resolved pin levels
    output wire m66en_in,
    output wire pcixcap_in,
    output wire bus_clk4_in,
    output wire irq_line_first_in,
    output wire [2:0] irq_lines_in
);
    // Open-drain: a device drive wins over the resistor
    assign m66en_in = m66_strap & !m66en_oe;
    assign pcixcap_in = cap_strap;
    // Agent data only once the device lets go of the pin
    assign bus_clk4_in = bus_clk4_oe ? bus_clk4_out : sdata;
    assign irq_line_first_in = irq_pins[0] & !irq_line_first_oe;
    assign irq_lines_in = irq_pins[3:1];
endmodule // sbr_agent

// File: tb/test_sbr_secondary_reset.sv
// Testbench of the secondary reset block
`timescale 1ns/10ps
module test_sbr_secondary_reset;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg m66 = 0, cap = 0, sdata = 0, perr_in = 0, pwr_ev = 0, err;
    reg [3:0] pins = 4'hF;
    reg [31:0] rd, st;
    integer seed = 82, failures = 0, samples_checked = 0, i;
    wire [31:0] prdata;
    wire [3:0] bus_clk;
    wire [2:0] irq_lines_in;
    wire pready, pslverr, sec_reset_n, m66en_in, m66en_out, m66en_oe, pcixcap_in, bus_clk4_in, bus_clk4_out;
    wire bus_clk4_oe, hp_serial_in_data, bus_66mhz, bus_pcix, perr_n_out, perr_n_oe, irq_line_first_in;
    wire irq_line_first_out, irq_line_first_oe, pme_n_out, pme_n_oe, req64_n_out, req64_n_oe, irq;
    always #10 pclk = ~pclk;
    sbr_secondary_reset i_sbr_secondary_reset (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sec_reset_n(sec_reset_n), .m66en_in(m66en_in), .m66en_out(m66en_out), .m66en_oe(m66en_oe),
        .pcixcap_in(pcixcap_in), .bus_clk(bus_clk), .bus_clk4_in(bus_clk4_in), .bus_clk4_out(bus_clk4_out),
        .bus_clk4_oe(bus_clk4_oe), .hp_serial_in_data(hp_serial_in_data), .bus_66mhz(bus_66mhz),
        .bus_pcix(bus_pcix), .sec_parity_err(perr_in), .perr_n_out(perr_n_out), .perr_n_oe(perr_n_oe),
        .irq_line_first_in(irq_line_first_in), .irq_line_first_out(irq_line_first_out),
        .irq_line_first_oe(irq_line_first_oe), .irq_lines_in(irq_lines_in), .hp_power_event(pwr_ev),
        .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe), .req64_n_out(req64_n_out), .req64_n_oe(req64_n_oe), .irq(irq));
    sbr_agent i_sbr_agent (.m66_strap(m66), .cap_strap(cap), .sdata(sdata), .irq_pins(pins),
        .m66en_oe(m66en_oe), .irq_line_first_oe(irq_line_first_oe), .bus_clk4_oe(bus_clk4_oe),
        .bus_clk4_out(bus_clk4_out), .m66en_in(m66en_in), .pcixcap_in(pcixcap_in), .bus_clk4_in(bus_clk4_in),
        .irq_line_first_in(irq_line_first_in), .irq_lines_in(irq_lines_in));
    task tally_and_finish;
        begin
            $display("Compared %0d values, %0d mismatches", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0d ns: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1;
            penable <= 0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            if (pready !== 1'b1) begin
                failures = failures + 1;
                tally_and_finish;
            end
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    // Status word with the secondary reset released
    function [31:0] exp_stat(input m, input c);
        exp_stat = {29'h0, 1'b1, c, m};
    endfunction
    initial begin
        repeat (10) @(posedge pclk);
        chk({sec_reset_n, req64_n_oe}, 2'b01);
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, 8'h54, 0);
        chk(rd, 32'h4);
        apb(1, 8'h58, 32'h7);
        for (i = 0; i < 6; i = i + 1) begin
            apb(1, 8'h3C, 1);
            repeat (2) @(posedge pclk);
            chk({sec_reset_n, req64_n_oe}, 2'b01);
            st = $random(seed);
            m66 <= st[0];
            cap <= st[1];
            apb(1, 8'h3C, 0);
            repeat (2) @(posedge pclk);
            m66 <= ~st[0];
            cap <= ~st[1];
            repeat (3) @(posedge pclk);
            chk({bus_pcix, bus_66mhz}, st[1:0]);
            apb(0, 8'h50, 0);
            chk(rd & 32'h7, exp_stat(st[0], st[1]));
        end
        // Mask and status survive the secondary reset
        chk(irq, 1);
        apb(0, 8'h58, 0);
        chk(rd, 32'h7);
        apb(0, 8'h54, 0);
        chk(rd, 32'h4);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
        apb(1, 8'h10, 32'hFFFFFFFF);
        apb(0, 8'h3C, 0);
        chk({err, rd[30:0]}, 32'h0);
        apb(0, 8'h40, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1, 8'h58, 32'h1);
        perr_in <= 1;
        @(posedge pclk);
        perr_in <= 0;
        pwr_ev <= 1;
        @(posedge pclk);
        pwr_ev <= 0;
        repeat (2) @(posedge pclk);
        chk({irq, pme_n_oe}, 2'b11);
        apb(0, 8'h54, 0);
        chk(rd, 32'h3);
        repeat (2) @(posedge pclk);
        chk({irq, pme_n_oe}, 2'b00);
        rd = {bus_clk4_out, bus_clk};
        @(posedge pclk);
        chk({bus_clk4_out, bus_clk}, {27'h0, ~rd[4:0]});
        apb(1, 8'h48, 32'hF);
        for (i = 0; i < 8; i = i + 1) begin
            sdata <= $random(seed);
            pins <= $random(seed);
            repeat (3) @(posedge pclk);
            chk({m66en_oe, irq_line_first_oe, bus_clk4_oe, m66en_in, irq_line_first_in}, 5'b11000);
            chk(hp_serial_in_data, sdata);
            apb(0, 8'h50, 0);
            chk({rd[11:8], rd[4:3]}, {pins & 4'hE, sdata, 1'b1});
        end
        chk({m66en_out, perr_n_out, irq_line_first_out, pme_n_out, req64_n_out}, 5'h0);
        // Release in hot plug mode keeps the old speed strap
        st = $random(seed);
        rd = {bus_pcix, bus_66mhz};
        m66 <= ~rd[0];
        cap <= st[1];
        apb(1, 8'h3C, 1);
        repeat (3) @(posedge pclk);
        chk({m66en_oe, req64_n_oe}, 2'b01);
        apb(1, 8'h3C, 0);
        repeat (5) @(posedge pclk);
        chk({bus_pcix, bus_66mhz}, {st[1], rd[0]});
        tally_and_finish;
    end
endmodule // test_sbr_secondary_reset
